//--- rtl/frame_phase_ctrl.v
// Frame phase sequencer, overrun detection and reset cause registers
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "frame_phase_map.vh"

module frame_phase_ctrl (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // Register port
    input  wire [1:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWrite,
    input  wire       regRead,
    output reg  [7:0] regRdData,
    // Clock generator and CPU
    input  wire       frameStart,
    input  wire       stopExec,
    input  wire       stopSlowClockSelect,
    input  wire       debugModeEnable,
    input  wire       analogDone,
    // Reset sources
    input  wire       pinResetIn,
    input  wire       debugResetIn,
    input  wire       illegalAddrIn,
    input  wire       illegalOpIn,
    input  wire       swResetIn,
    // Outputs
    output reg        startAnalog,
    output reg        startDigital,
    output wire       digitalIrq,
    output reg        overrunNmi,
    output reg        swResetReq,
    output wire       resetPinDriveLow,
    output wire [1:0] phase
);

    ////////////////////////////////////////////////////////////////////////
    // Control register state
    localparam [7:0] FRAME_RESET = `FC_RESET_VAL;
    localparam [1:0] ST_IDLE     = `PH_IDLE;
    localparam [1:0] ST_ANALOG   = `PH_ANALOG;
    localparam [1:0] ST_DIGITAL  = `PH_DIGITAL;

    reg  [1:0]            phase_q;
    reg  [1:0]            phase_d;
    reg                   startAnalog_d;
    reg                   startDigital_d;
    reg                   analogEn_q;
    reg                   analogEn_d;
    reg  [1:0]            checkSel_q;
    reg  [1:0]            checkSel_d;
    reg                   digIrqEn_q;
    reg                   digIrqEn_d;
    reg                   overrunNmi_d;
    reg                   swResetReq_d;
    reg  [7:0]            regRdData_d;
    wire [`NUM_FLAGS-1:0] flagSet;
    wire [`NUM_FLAGS-1:0] flagClr;
    wire [`NUM_FLAGS-1:0] flags;
    wire                  overrunFlag;
    wire                  digStartFlag;
    wire [4:0]            cause;
    wire                  pinDrive;
    wire [7:0]            frameWord;
    wire [7:0]            causeWord;

    function checkActive;
        input [1:0] sel;
        input       dbg;
        begin
            case (sel)
                `CHK_NODEBUG: checkActive = ~dbg;
                `CHK_ALWAYS:  checkActive = 1'b1;
                default:      checkActive = 1'b0;
            endcase
        end
    endfunction

    function isAddr;
        input [1:0] a;
        input [1:0] target;
        begin
            isAddr = (a == target);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register port decode
    wire wrFrame = regWrite & isAddr(regAddr, `ADDR_FRAME_CTRL);
    wire wrCause = regWrite & isAddr(regAddr, `ADDR_RESET_CAUSE);
    wire rdFrame = regRead & isAddr(regAddr, `ADDR_FRAME_CTRL);
    wire rdCause = regRead & isAddr(regAddr, `ADDR_RESET_CAUSE);

    // Overrun check: frame start while still running
    wire inRun      = (phase_q != ST_IDLE);
    wire frameError = frameStart & inRun & checkActive(checkSel_q, debugModeEnable);
    wire fromIdle   = frameStart & ~inRun;

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer, next state
    always @* begin
        phase_d        = phase_q;
        startAnalog_d  = 1'b0;
        startDigital_d = 1'b0;
        case (phase_q)
            ST_IDLE: begin
                if (fromIdle && analogEn_q) begin
                    phase_d       = ST_ANALOG;
                    startAnalog_d = 1'b1;
                end else if (fromIdle) begin
                    phase_d        = ST_DIGITAL;
                    startDigital_d = 1'b1;
                end
            end
            ST_ANALOG: begin
                if (analogDone) begin
                    phase_d        = ST_DIGITAL;
                    startDigital_d = 1'b1;
                end
            end
            ST_DIGITAL: begin
                if (stopExec && stopSlowClockSelect) begin
                    phase_d = ST_IDLE;
                end
            end
            default: begin
                phase_d = ST_IDLE;
            end
        endcase
    end

    // Phase register and one-cycle start pulses
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q      <= ST_IDLE;
            startAnalog  <= 1'b0;
            startDigital <= 1'b0;
        end else begin
            phase_q      <= phase_d;
            startAnalog  <= startAnalog_d;
            startDigital <= startDigital_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame control configuration fields
    always @* begin
        analogEn_d = analogEn_q;
        checkSel_d = checkSel_q;
        digIrqEn_d = digIrqEn_q;
        if (wrFrame) begin
            analogEn_d = regWrData[`FC_ANALOG_EN];
            checkSel_d = regWrData[`FC_CHECK_HI:`FC_CHECK_LO];
            digIrqEn_d = regWrData[`FC_DIG_IRQ_EN];
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            analogEn_q <= FRAME_RESET[`FC_ANALOG_EN];
            checkSel_q <= FRAME_RESET[`FC_CHECK_HI:`FC_CHECK_LO];
            digIrqEn_q <= FRAME_RESET[`FC_DIG_IRQ_EN];
        end else begin
            analogEn_q <= analogEn_d;
            checkSel_q <= checkSel_d;
            digIrqEn_q <= digIrqEn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write-one-to-clear status flags; a set in the clear cycle wins
    assign flagSet[`FLAG_DIG_START] = startDigital;
    assign flagSet[`FLAG_OVERRUN]   = frameError;
    assign flagClr[`FLAG_DIG_START] = wrFrame & regWrData[`FC_DIG_START];
    assign flagClr[`FLAG_OVERRUN]   = wrFrame & regWrData[`FC_OVERRUN];

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_FLAGS; gi = gi + 1) begin : w1cFlag
            reg flag_q;
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q <= 1'b0;
                end else if (flagSet[gi]) begin
                    flag_q <= 1'b1;
                end else if (flagClr[gi]) begin
                    flag_q <= 1'b0;
                end
            end
            assign flags[gi] = flag_q;
        end
    endgenerate

    assign overrunFlag  = flags[`FLAG_OVERRUN];
    assign digStartFlag = flags[`FLAG_DIG_START];
    assign digitalIrq   = digIrqEn_q & digStartFlag;
    assign phase        = phase_q;

    ////////////////////////////////////////////////////////////////////////
    // Event pulses: overrun interrupt and software reset request
    always @* begin
        overrunNmi_d = frameError;
        swResetReq_d = wrCause & regWrData[`RC_SOFT_REQ];
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrunNmi <= 1'b0;
            swResetReq <= 1'b0;
        end else begin
            overrunNmi <= overrunNmi_d;
            swResetReq <= swResetReq_d;
        end
    end

    reset_cause_recorder causeRec (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .pinResetIn    (pinResetIn),
        .debugResetIn  (debugResetIn),
        .illegalAddrIn (illegalAddrIn),
        .illegalOpIn   (illegalOpIn),
        .swResetIn     (swResetIn),
        .drvWrite      (wrCause),
        .drvWriteVal   (regWrData[`RC_PIN_DRIVE]),
        .cause_q       (cause),
        .pinDrive_q    (pinDrive),
        .pinDriveLow   (resetPinDriveLow)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read words; reserved positions stay zero
    assign frameWord = {2'h0, analogEn_q, checkSel_q, overrunFlag, digIrqEn_q, digStartFlag};
    assign causeWord = {1'h0, pinDrive, 1'h0, cause};

    // Read data, one cycle after the strobe, zero otherwise
    always @* begin
        regRdData_d = 8'h00;
        if (rdFrame) begin
            regRdData_d = frameWord;
        end else if (rdCause) begin
            regRdData_d = causeWord;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRdData_d;
        end
    end

endmodule

//--- rtl/frame_phase_map.vh
// Register map, field positions and codes of the frame phase and reset cause block
`ifndef FRAME_PHASE_MAP_VH
`define FRAME_PHASE_MAP_VH

// Register offsets (word index on the plain register port)
`define ADDR_FRAME_CTRL     2'h0
`define ADDR_RESET_CAUSE    2'h1

// frame_control_reg fields
`define FC_ANALOG_EN        5
`define FC_CHECK_HI         4
`define FC_CHECK_LO         3
`define FC_OVERRUN          2
`define FC_DIG_IRQ_EN       1
`define FC_DIG_START        0
`define FC_RESET_VAL        8'h20

// Error check select codes
`define CHK_OFF             2'h0
`define CHK_NODEBUG         2'h1
`define CHK_RSVD            2'h2
`define CHK_ALWAYS          2'h3

// reset_cause_reg fields
`define RC_PIN_DRIVE        6
`define RC_SOFT_REQ         5
`define RC_SOFT             4
`define RC_BAD_OPCODE       3
`define RC_BAD_ADDR         2
`define RC_PIN              1
`define RC_POR              0
`define RC_CAUSE_POR        5'h01
`define RC_CAUSE_PIN        5'h02
`define RC_CAUSE_BAD_ADDR   5'h04
`define RC_CAUSE_BAD_OPCODE 5'h08
`define RC_CAUSE_SOFT       5'h10
`define RC_CAUSE_NONE       5'h00

// Slots of the write-one-to-clear flag bank
`define FLAG_DIG_START      0
`define FLAG_OVERRUN        1
`define NUM_FLAGS           2

// Phase encodings
`define PH_IDLE             2'h0
`define PH_ANALOG           2'h1
`define PH_DIGITAL          2'h2

`endif

//--- rtl/reset_cause_recorder.v
// Reset cause recorder with precedence encoding and pin drive control
`timescale 1ns/1ps
`include "frame_phase_map.vh"

module reset_cause_recorder (
    // Clock and power-on reset
    input  wire       core_clk,
    input  wire       rst_n,
    // Reset sources, level while asserted
    input  wire       pinResetIn,
    input  wire       debugResetIn,
    input  wire       illegalAddrIn,
    input  wire       illegalOpIn,
    input  wire       swResetIn,
    // Software writes
    input  wire       drvWrite,
    input  wire       drvWriteVal,
    // State
    output reg  [4:0] cause_q,
    output reg        pinDrive_q,
    output wire       pinDriveLow
);

    ////////////////////////////////////////////////////////////////////////
    reg          swPend_q;
    reg          swPrev_q;
    wire         swExit = swPrev_q & ~swResetIn;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_q    <= `RC_CAUSE_POR;
            pinDrive_q <= 1'b0;
            swPend_q   <= 1'b0;
            swPrev_q   <= 1'b0;
        end else begin
            swPrev_q <= swResetIn;
            if (drvWrite) begin
                pinDrive_q <= drvWriteVal;
            end
            if (pinResetIn) begin
                cause_q  <= `RC_CAUSE_PIN;
                swPend_q <= 1'b0;
            end else if (debugResetIn) begin
                cause_q  <= `RC_CAUSE_NONE;
                swPend_q <= 1'b0;
            end else if (illegalAddrIn) begin
                cause_q  <= `RC_CAUSE_BAD_ADDR;
                swPend_q <= 1'b0;
            end else if (illegalOpIn) begin
                cause_q  <= `RC_CAUSE_BAD_OPCODE;
                swPend_q <= 1'b0;
            end else if (swResetIn) begin
                swPend_q <= 1'b1;
            end else if (swExit && swPend_q) begin
                cause_q  <= `RC_CAUSE_SOFT;
                swPend_q <= 1'b0;
            end
        end
    end

    // Internal resets pull the pin when enabled
    assign pinDriveLow = pinDrive_q & (debugResetIn | illegalAddrIn | illegalOpIn | swResetIn);

endmodule

//--- testbench/frame_phase_ctrl_chk.sv
// Port checker of the frame phase and reset cause block
`timescale 1ns/1ps
`include "frame_phase_map.vh"

module frame_phase_ctrl_chk (
    // Clock and reset
    input wire       core_clk,
    input wire       rst_n,
    // Register port
    input wire [1:0] regAddr,
    input wire [7:0] regWrData,
    input wire       regWrite,
    input wire       regRead,
    input wire [7:0] regRdData,
    // Frame events
    input wire       frameStart,
    input wire       stopExec,
    input wire       stopSlowClockSelect,
    // Outputs
    input wire       startAnalog,
    input wire       startDigital,
    input wire       digitalIrq,
    input wire       overrunNmi,
    input wire       swResetReq,
    input wire [1:0] phase
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_launch; frameStart && phase == `PH_IDLE |=> startAnalog != startDigital; endproperty
    a_launch: assert property (p_launch) else $error("frame start in idle gave no single launch");
    property p_idle_ok; frameStart && phase == `PH_IDLE |=> !overrunNmi; endproperty
    a_idle_ok: assert property (p_idle_ok) else $error("overrun raised from idle");
    property p_nmi_cause; overrunNmi |-> $past(frameStart) && $past(phase) != `PH_IDLE; endproperty
    a_nmi_cause: assert property (p_nmi_cause) else $error("overrun without frame start in run");
    property p_dig; startDigital |-> phase == `PH_DIGITAL ##1 !startDigital; endproperty
    a_dig: assert property (p_dig) else $error("digital start pulse wrong");
    property p_ana; startAnalog |-> phase == `PH_ANALOG && !startDigital; endproperty
    a_ana: assert property (p_ana) else $error("analog start pulse wrong");
    property p_stop;
        phase == `PH_DIGITAL && stopExec && stopSlowClockSelect && !frameStart |=> phase == `PH_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not reach idle");
    property p_irq; $rose(digitalIrq) |-> $past(startDigital) || $past(regWrite); endproperty
    a_irq: assert property (p_irq) else $error("interrupt rose without cause");
    property p_unmap; regRead && regAddr[1] |=> regRdData == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_swreq;
        swResetReq |-> $past(regWrite) && $past(regAddr) == `ADDR_RESET_CAUSE && $past(regWrData[`RC_SOFT_REQ]);
    endproperty
    a_swreq: assert property (p_swreq) else $error("software reset request without write");

    c_ana: cover property (startAnalog);
    c_nmi: cover property (overrunNmi);
    c_sw: cover property (swResetReq);
endmodule

bind frame_phase_ctrl frame_phase_ctrl_chk chk_u (.*);

//--- testbench/analog_front_model.sv
// Analog front end stand-in that ends the analog phase after a delay
`timescale 1ns/1ps

module analog_front_model #(
    parameter DONE_DELAY = 3
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Phase handshake
    input  wire logic startAnalog,
    output logic      analogDone
);
    int cnt;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            analogDone <= 1'b0;
        end else begin
            analogDone <= (cnt == 1);
            if (startAnalog) cnt <= DONE_DELAY;
            else if (cnt != 0) cnt <= cnt - 1;
        end
    end
endmodule

//--- testbench/frame_phase_ctrl_tb.sv
// Self-checking bench of the frame phase and reset cause block
`timescale 1ns/1ps
`include "frame_phase_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end

module frame_phase_ctrl_tb;
    logic       core_clk, rst_n = 0, regWrite = 0, regRead = 0, frameStart = 0, stopExec = 0, stopSel = 0;
    logic       dbg = 0, analogDone, startAnalog, startDigital, digitalIrq, overrunNmi, swResetReq, drvLow;
    logic [1:0] regAddr = 0, phase;
    logic [7:0] regWrData = 0, regRdData;
    logic [4:0] srcs = 0;
    logic [4:0] srcTab [7] = '{5'h01, 5'h04, 5'h08, 5'h02, 5'h05, 5'h0C, 5'h0A};
    logic [4:0] causeTab [7] = '{5'h02, 5'h04, 5'h08, 5'h00, 5'h02, 5'h04, 5'h00};
    int         num_errors = 0, samples_checked = 0, nAna = 0, nDig = 0, nNmi = 0, nSw = 0, k;
    bit         e;

    frame_phase_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .frameStart(frameStart),
        .stopExec(stopExec), .stopSlowClockSelect(stopSel), .debugModeEnable(dbg), .analogDone(analogDone),
        .pinResetIn(srcs[0]), .debugResetIn(srcs[1]), .illegalAddrIn(srcs[2]), .illegalOpIn(srcs[3]),
        .swResetIn(srcs[4]), .startAnalog(startAnalog), .startDigital(startDigital), .digitalIrq(digitalIrq),
        .overrunNmi(overrunNmi), .swResetReq(swResetReq), .resetPinDriveLow(drvLow), .phase(phase));
    analog_front_model afe_u (.core_clk(core_clk), .rst_n(rst_n), .startAnalog(startAnalog),
        .analogDone(analogDone));

    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        nAna += startAnalog;
        nDig += startDigital;
        nNmi += overrunNmi;
        nSw += swResetReq;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        tick(1);
        regWrite <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] x, input string n);
        regAddr <= a;
        regRead <= 1'b1;
        tick(1);
        regRead <= 1'b0;
        #1 `CHK(n, x, regRdData)
        tick(1);
    endtask
    task automatic fs; frameStart <= 1'b1; tick(1); frameStart <= 1'b0; tick(1); endtask
    task automatic stop; stopExec <= 1'b1; tick(1); stopExec <= 1'b0; tick(1); endtask
    task automatic src(input logic [4:0] v); srcs <= v; tick(2); srcs <= 5'h00; tick(3); endtask
    task automatic end_of_test;
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(12);
        rst_n <= 1'b1;
        tick(1);
        rd(0, `FC_RESET_VAL, "frame reset");
        rd(1, 8'h01, "cause reset");
        rd(2, 8'h00, "unmapped");
        wr(0, 8'hFF);
        rd(0, 8'h3A, "frame cfg");
        fs();
        tick(8);
        `CHK("analog", 1, nAna)
        `CHK("digital", 1, nDig)
        `CHK("irq", 1'b1, digitalIrq)
        rd(0, 8'h3B, "start flag");
        fs();
        tick(1);
        `CHK("nmi", 1, nNmi)
        rd(0, 8'h3F, "overrun");
        wr(0, 8'h3F);
        rd(0, 8'h3A, "cleared");
        `CHK("irq off", 1'b0, digitalIrq)
        stop();
        `CHK("no stop", `PH_DIGITAL, phase)
        stopSel <= 1'b1;
        stop();
        `CHK("phase", `PH_IDLE, phase)
        for (int c = 0; c < 4; c++) for (int d = 0; d < 2; d++) begin
            e = (c == 3) || (c == 1 && d == 0);
            k = nNmi + e;
            dbg <= d[0];
            wr(0, {3'b000, c[1:0], 3'b101});
            fs();
            fs();
            tick(1);
            `CHK("nmi sel", k, nNmi)
            rd(0, {3'b000, c[1:0], e, 2'b01}, "sel flag");
            stop();
        end
        `CHK("skip analog", 1, nAna)
        `CHK("digital no irq", 9, nDig)
        for (int i = 0; i < 7; i++) begin
            src(srcTab[i]);
            rd(1, {3'b000, causeTab[i]}, "cause");
        end
        wr(1, 8'h40);
        srcs <= 5'h04;
        tick(2);
        `CHK("pin drive", 1'b1, drvLow)
        src(5'h00);
        rd(1, 8'h44, "drive cause");
        wr(1, 8'h60);
        tick(1);
        `CHK("sw req", 1, nSw)
        src(5'h10);
        rd(1, 8'h50, "sw cause");
        srcs <= 5'h01;
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(2);
        src(5'h00);
        rd(1, 8'h02, "pin after por");
        end_of_test();
    end

    initial begin
        tick(5000);
        num_errors++;
        end_of_test();
    end
endmodule
